// [core/spi_port_pkg.sv]
// Purpose: Shared constants and types of the serial port block
// Assumes: APB register bus, 32-bit data, pclk at 50 MHz
// Notes: Offsets are byte addresses
package spi_port_pkg;
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_IMASK = 8'h14;
	localparam logic [7:0] OFS_ISTAT = 8'h18;
	// Field positions of the control registers
	localparam int SIZE_LSB = 0;
	localparam int EN_BIT = 1;
	localparam int ROLE_BIT = 2;
	localparam int SOD_BIT = 3;
	localparam int RXO_LSB = 4;
	localparam int RXT_LSB = 7;
	localparam int TXT_LSB = 10;
	localparam int WAIT_LSB = 14;
	localparam int TXO_LSB = 18;
	localparam int DLY_BIT = 21;
	// Status and interrupt bit positions
	localparam int ST_TFE = 0;
	localparam int ST_TNF = 1;
	localparam int ST_RNE = 2;
	localparam int ST_RFF = 3;
	localparam int ST_BSY = 4;
	localparam int IRQ_RXTH = 0;
	localparam int IRQ_TXTH = 1;
	localparam int IRQ_OVR = 2;
	// Reset values
	localparam logic [4:0] SIZE_RST = 5'h00;
	localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
	localparam logic [2:0] IMASK_RST = 3'h0;
	// Threshold codes and frame size limits
	localparam logic [2:0] THR_FOUR = 3'h1;
	localparam logic [2:0] THR_EIGHT = 3'h2;
	localparam logic [4:0] MIN_SIZE = 5'h03;
	// Serial clock timing in master role
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCK_HALF_NS = 80;
	localparam logic [7:0] SCK_HALF_CYC = 8'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_SHIFT = 3'b010,
		PH_WAIT = 3'b100
	} phase_t;
endpackage

// [core/fifo_if.sv]
// Purpose: Push and pop channel between the port and a FIFO store
// Assumes: One clock domain
// Notes: rdata always shows the oldest element
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 32, parameter int CW = 4);
	logic push;
	logic [W-1:0] wdata;
	logic pop;
	logic [W-1:0] rdata;
	logic full;
	logic empty;
	logic [CW-1:0] count;
	modport user(output push, output wdata, output pop, input rdata, input full, input empty, input count);
	modport store(input push, input wdata, input pop, output rdata, output full, output empty, output count);
endinterface

// [core/fifo_store.sv]
// Purpose: Small FIFO store with registered head output
// Assumes: DEPTH a power of two; push when full and pop when empty are ignored
// Notes: Head data and flags come from registers
`timescale 1ns/1ps
module fifo_store #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	fifo_if.store f
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic [W-1:0] head;
	} store_t;
	store_t q;
	store_t d;
	logic do_push;
	logic do_pop;
	always_comb begin
		d = q;
		do_push = f.push && (q.cnt != CW'(DEPTH));
		do_pop = f.pop && (q.cnt != '0);
		if (do_push) begin
			d.mem[q.wp] = f.wdata;
			d.wp = q.wp + PW'(1);
		end
		if (do_pop) begin
			d.rp = q.rp + PW'(1);
		end
		d.cnt = q.cnt + CW'(do_push) - CW'(do_pop);
		d.head = d.mem[d.rp];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end
	assign f.rdata = q.head;
	assign f.count = q.cnt;
	assign f.full = (q.cnt == CW'(DEPTH));
	assign f.empty = (q.cnt == '0);
endmodule

// [core/spi_port.sv]
// Purpose: Serial port control and data path with APB registers
// Assumes: Clock idle low; data change on the falling serial clock, input sampled at the end of the high half as master, on the rising edge as slave
// Notes: Link pins arrive unsynchronised and pass two flip-flops first
// Behaviour
// - Port runs only while enable bit set
// - Role bit zero master, one slave
// - Slave output disable keeps data-out undriven
// - Receive ordering selects byte and bit order
// - Transmit ordering uses same four combinations
// - Receive interrupt when level reaches threshold
// - Transmit interrupt threshold from bits 12:10
// - Wait field inserts states between frames
// - Input delay bit adds two cycles
// - Data read pops receive, write pushes transmit
// - Transmitter ignores bits above frame size
// - Received frames delivered right-aligned
// - Frame length is size field plus one, a size below 3 taken as 3
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module spi_port
	import spi_port_pkg::*;
#(
	parameter int DEPTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic cs_n_in,
	output logic cs_n_out,
	output logic cs_n_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe
);
	localparam int CW = $clog2(DEPTH + 1);
	if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("DEPTH must be a power of two of at least 8");
	end

	typedef struct packed {
		logic [4:0] size;
		logic en;
		logic role;
		logic slave_output_disable;
		logic dly;
		logic [1:0] rxo;
		logic [1:0] txo;
		logic [2:0] rxt;
		logic [2:0] txt;
		logic [3:0] wt;
		logic [2:0] imask;
		logic [2:0] istat;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0] sck_s;
		logic [1:0] cs_s;
		logic [1:0] mosi_s;
		logic [1:0] miso_s;
		logic sck_l;
		logic cs_l;
		logic [1:0] dpipe;
		phase_t ph;
		logic [7:0] div;
		logic [5:0] bits;
		logic [4:0] wcnt;
		logic [31:0] tsh;
		logic [31:0] rsh;
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic cs_n_o;
		logic cs_n_oe;
		logic irq;
	} state_t;

	state_t q;
	state_t d;
	fifo_if #(.W(32), .CW(CW)) tx_f();
	fifo_if #(.W(32), .CW(CW)) rx_f();

	fifo_store #(.W(32), .DEPTH(DEPTH)) u_tx_store (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.f(tx_f)
	);
	fifo_store #(.W(32), .DEPTH(DEPTH)) u_rx_store (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.f(rx_f)
	);

	// Reorders bytes and bits within an n-bit element; its own inverse when n is a multiple of 8
	function automatic logic [31:0] arrange(input logic [31:0] x, input logic [5:0] n, input logic [1:0] code);
		logic [31:0] a;
		logic [31:0] r;
		int nb;
		a = '0;
		r = '0;
		nb = int'(n) / 8;
		for (int i = 0; i < 32; i++) begin
			if (i < int'(n)) begin
				a[i] = code[1] ? x[int'(n) - 1 - i] : x[i];
			end
		end
		if (code == 2'b01 || code == 2'b10) begin
			for (int i = 0; i < 32; i++) begin
				if (i < nb * 8) begin
					r[i] = a[(nb - 1 - i / 8) * 8 + i % 8];
				end
			end
		end else begin
			r = a;
		end
		return r;
	endfunction

	function automatic int level(input logic [2:0] code);
		int v;
		v = 1;
		if (code == THR_FOUR) begin
			v = 4;
		end else if (code == THR_EIGHT) begin
			v = 8;
		end
		return v;
	endfunction

	logic acc;
	logic [5:0] n;
	logic din;
	logic rise;
	logic fall;
	logic cs_fall;
	logic tx_pop;
	logic rx_pop;
	logic tx_push;
	logic rx_push;
	logic [31:0] rword;
	logic [31:0] tword;
	logic [31:0] rd;
	logic [2:0] ev;

	always_comb begin
		d = q;
		acc = psel && penable;
		tx_pop = 1'b0;
		rx_pop = 1'b0;
		tx_push = 1'b0;
		rx_push = 1'b0;
		rword = '0;
		tword = '0;
		rd = '0;
		ev = '0;
		n = {1'b0, (q.size < MIN_SIZE) ? MIN_SIZE : q.size} + 6'd1;

		// Link inputs: two-flop synchronisers, then edge detection
		d.sck_s = {q.sck_s[0], sck_in};
		d.cs_s = {q.cs_s[0], cs_n_in};
		d.mosi_s = {q.mosi_s[0], mosi_in};
		d.miso_s = {q.miso_s[0], miso_in};
		d.sck_l = q.sck_s[1];
		d.cs_l = q.cs_s[1];
		d.dpipe = {q.dpipe[0], q.role ? q.mosi_s[1] : q.miso_s[1]};
		din = q.dly ? q.dpipe[1] : (q.role ? q.mosi_s[1] : q.miso_s[1]);
		rise = q.sck_s[1] && !q.sck_l;
		fall = !q.sck_s[1] && q.sck_l;
		cs_fall = q.cs_l && !q.cs_s[1];

		// APB: registered answer in the second access cycle
		if (acc && !q.pready) begin
			d.pready = 1'b1;
			d.pslverr = 1'b0;
			unique case (paddr)
				OFS_CTRL0: rd[SIZE_LSB +: 5] = q.size;
				OFS_CTRL1: begin
					rd[EN_BIT] = q.en;
					rd[ROLE_BIT] = q.role;
					rd[SOD_BIT] = q.slave_output_disable;
					rd[RXO_LSB +: 2] = q.rxo;
					rd[RXT_LSB +: 3] = q.rxt;
					rd[TXT_LSB +: 3] = q.txt;
					rd[WAIT_LSB +: 4] = q.wt;
					rd[TXO_LSB +: 2] = q.txo;
					rd[DLY_BIT] = q.dly;
				end
				OFS_DATA: rd = rx_f.empty ? '0 : rx_f.rdata;
				OFS_STAT: begin
					rd[ST_TFE] = tx_f.empty;
					rd[ST_TNF] = !tx_f.full;
					rd[ST_RNE] = !rx_f.empty;
					rd[ST_RFF] = rx_f.full;
					rd[ST_BSY] = (q.ph != PH_IDLE) || !tx_f.empty;
				end
				OFS_IMASK: rd[2:0] = q.imask;
				OFS_ISTAT: rd[2:0] = q.istat;
				default: d.pslverr = 1'b1;
			endcase
			d.prdata = rd;
		end
		if (acc && q.pready) begin
			d.pready = 1'b0;
			d.pslverr = 1'b0;
			if (pwrite) begin
				unique case (paddr)
					OFS_CTRL0: d.size = pwdata[SIZE_LSB +: 5];
					OFS_CTRL1: begin
						d.en = pwdata[EN_BIT];
						d.role = pwdata[ROLE_BIT];
						d.slave_output_disable = pwdata[SOD_BIT];
						d.rxo = pwdata[RXO_LSB +: 2];
						d.rxt = pwdata[RXT_LSB +: 3];
						d.txt = pwdata[TXT_LSB +: 3];
						d.wt = pwdata[WAIT_LSB +: 4];
						d.txo = pwdata[TXO_LSB +: 2];
						d.dly = pwdata[DLY_BIT];
					end
					OFS_DATA: tx_push = !tx_f.full;
					OFS_IMASK: d.imask = pwdata[2:0];
					default: ;
				endcase
			end else if (paddr == OFS_DATA) begin
				rx_pop = !rx_f.empty;
			end else if (paddr == OFS_ISTAT) begin
				d.istat = '0;
			end
		end

		// Serial engine
		if (!q.en) begin
			d.ph = PH_IDLE;
			d.bits = '0;
			d.sck_o = 1'b0;
			d.cs_n_o = 1'b1;
			d.sck_oe = 1'b0;
			d.mosi_oe = 1'b0;
			d.cs_n_oe = 1'b0;
			d.miso_oe = 1'b0;
		end else if (!q.role) begin
			d.sck_oe = 1'b1;
			d.mosi_oe = 1'b1;
			d.cs_n_oe = 1'b1;
			d.miso_oe = 1'b0;
			unique case (q.ph)
				PH_IDLE: begin
					if (!tx_f.empty) begin
						tx_pop = 1'b1;
						tword = arrange(tx_f.rdata, n, q.txo) << (6'd32 - n);
						d.tsh = tword;
						d.mosi_o = tword[31];
						d.cs_n_o = 1'b0;
						d.sck_o = 1'b0;
						d.div = '0;
						d.bits = '0;
						d.ph = PH_SHIFT;
					end
				end
				PH_SHIFT: begin
					if (q.div == SCK_HALF_CYC - 8'd1) begin
						d.div = '0;
						if (!q.sck_o) begin
							d.sck_o = 1'b1;
							d.bits = q.bits + 6'd1;
						end else begin
							// Sample at the end of the high half so sync and input delay fit inside it
							d.sck_o = 1'b0;
							d.rsh = {q.rsh[30:0], din};
							if (q.bits == n) begin
								rx_push = 1'b1;
								rword = {q.rsh[30:0], din};
								d.cs_n_o = 1'b1;
								d.wcnt = {q.wt, 1'b0};
								d.ph = (q.wt == '0) ? PH_IDLE : PH_WAIT;
							end else begin
								d.tsh = {q.tsh[30:0], 1'b0};
								d.mosi_o = q.tsh[30];
							end
						end
					end else begin
						d.div = q.div + 8'd1;
					end
				end
				PH_WAIT: begin
					if (q.div == SCK_HALF_CYC - 8'd1) begin
						d.div = '0;
						d.wcnt = q.wcnt - 5'd1;
						if (q.wcnt == 5'd1) begin
							d.ph = PH_IDLE;
						end
					end else begin
						d.div = q.div + 8'd1;
					end
				end
				default: d.ph = PH_IDLE;
			endcase
		end else begin
			d.sck_oe = 1'b0;
			d.mosi_oe = 1'b0;
			d.cs_n_oe = 1'b0;
			d.cs_n_o = 1'b1;
			d.miso_oe = !q.cs_s[1] && !q.slave_output_disable;
			if (q.cs_s[1]) begin
				d.ph = PH_IDLE;
				d.bits = '0;
			end else begin
				d.ph = PH_SHIFT;
				if (cs_fall || (fall && q.bits == '0)) begin
					tx_pop = !tx_f.empty;
					tword = tx_f.empty ? '0 : arrange(tx_f.rdata, n, q.txo) << (6'd32 - n);
					d.tsh = tword;
					d.miso_o = tword[31];
					d.bits = '0;
				end else if (fall) begin
					d.tsh = {q.tsh[30:0], 1'b0};
					d.miso_o = q.tsh[30];
				end else if (rise) begin
					d.rsh = {q.rsh[30:0], din};
					d.bits = q.bits + 6'd1;
					if (q.bits + 6'd1 == n) begin
						rx_push = 1'b1;
						rword = {q.rsh[30:0], din};
						d.bits = '0;
					end
				end
			end
		end

		// Interrupt events; a set in the clearing cycle wins
		ev[IRQ_RXTH] = int'(rx_f.count) >= level(q.rxt);
		ev[IRQ_TXTH] = int'(tx_f.count) >= level(q.txt);
		ev[IRQ_OVR] = rx_push && rx_f.full;
		d.istat = d.istat | ev;
		d.irq = |(d.istat & q.imask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.size <= SIZE_RST;
			q.en <= CTRL1_RST[EN_BIT];
			q.imask <= IMASK_RST;
			q.ph <= PH_IDLE;
			q.cs_n_o <= 1'b1;
			q.sck_s <= 2'h0;
			q.cs_s <= 2'h3;
			q.sck_l <= 1'b0;
			q.cs_l <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign tx_f.push = tx_push;
	assign tx_f.wdata = pwdata;
	assign tx_f.pop = tx_pop;
	assign rx_f.push = rx_push && !rx_f.full;
	assign rx_f.wdata = arrange(rword, n, q.rxo);
	assign rx_f.pop = rx_pop;

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign irq = q.irq;
	assign sck_out = q.sck_o;
	assign sck_oe = q.sck_oe;
	assign cs_n_out = q.cs_n_o;
	assign cs_n_oe = q.cs_n_oe;
	assign mosi_out = q.mosi_o;
	assign mosi_oe = q.mosi_oe;
	assign miso_out = q.miso_o;
	assign miso_oe = q.miso_oe;
endmodule

// [bench/spi_port_properties.sv]
// Purpose: Pin-level timing checks of the serial port
// Assumes: Sees only the top-level ports
// Notes: Bound into every spi_port instance
`timescale 1ns/1ps
module spi_port_properties
	import spi_port_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic cs_n_out,
	input wire logic mosi_out,
	input wire logic mosi_oe,
	input wire logic miso_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic unmapped;
	assign unmapped = !(paddr inside {OFS_CTRL0, OFS_CTRL1, OFS_DATA, OFS_STAT, OFS_IMASK, OFS_ISTAT});
	sequence sck_high_half;
		sck_out [*4] ##1 !sck_out;
	endsequence
	a_ready_once: assert property (pready |=> !pready) else $error("pready held too long");
	a_ready_latency: assert property (ce && psel && penable && !pready |=> pready)
		else $error("pready late");
	a_err_unmapped: assert property (pready |-> pslverr == unmapped) else $error("pslverr wrong");
	a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not 0");
	a_role_apart: assert property (!(miso_oe && (mosi_oe || sck_oe))) else $error("both roles drive");
	a_frame_min: assert property ($fell(cs_n_out) |=> !cs_n_out [*8]) else $error("frame too short");
	a_sck_half: assert property ($rose(sck_out) |-> sck_high_half) else $error("sck half period");
	a_mosi_steady: assert property (sck_out && $past(sck_out) |-> $stable(mosi_out))
		else $error("mosi moved while sck high");
	a_sck_idle: assert property (cs_n_out |-> !sck_out) else $error("sck runs between frames");
endmodule
bind spi_port spi_port_properties chk (.pclk, .presetn, .ce, .psel, .penable, .paddr, .prdata, .pready,
	.pslverr, .sck_out, .sck_oe, .cs_n_out, .mosi_out, .mosi_oe, .miso_oe);

// [bench/spi_peer_model.sv]
// Purpose: Serial slave device seen by the port in master role
// Assumes: Clock idle low, sample on rise, shift on fall, 16-bit frames
// Notes: Released data line shows the inverse of its last value
`timescale 1ns/1ps
module spi_peer_model (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	input wire logic [15:0] reply,
	output logic [15:0] heard
);
	logic [15:0] sh;
	initial begin
		miso = 1'b0;
		heard = 16'h0;
		sh = 16'h0;
	end
	always @(negedge cs_n) begin
		sh = reply;
		heard = 16'h0;
		miso = sh[15];
	end
	always @(posedge sck) if (!cs_n) heard = {heard[14:0], mosi};
	always @(negedge sck) if (!cs_n) begin
		sh = {sh[14:0], 1'b0};
		miso = sh[15];
	end
	always @(posedge cs_n) miso = ~miso;
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench of the serial port
// Assumes: pclk 50 MHz, link clock 160 ns
// Notes: Ordering cases run from a table, the rest by hand
`timescale 1ns/1ps
module testbench;
	import spi_port_pkg::*;
	typedef struct {logic [1:0] code; logic [15:0] line_v; logic [15:0] rx_v;} order_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic sck_in = 1'b0;
	logic cs_n_in = 1'b1;
	logic mosi_in = 1'b0;
	logic [15:0] reply = 16'h9c31;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, sck_out, sck_oe, cs_n_out, cs_n_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic peer_miso, miso_in, oe_seen;
	logic [15:0] heard, got;
	int errors = 0;
	int comparisons = 0;
	int gap = 0;
	int last_gap = 0;
	order_row_t rows [4] = '{'{2'h0, 16'h12c5, 16'h9c31}, '{2'h1, 16'hc512, 16'h319c},
		'{2'h2, 16'h48a3, 16'h398c}, '{2'h3, 16'ha348, 16'h8c39}};
	always #10 pclk = ~pclk;
	assign miso_in = miso_oe ? miso_out : peer_miso;
	spi_port dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .sck_in, .sck_out, .sck_oe, .cs_n_in, .cs_n_out, .cs_n_oe, .mosi_in, .mosi_out,
		.mosi_oe, .miso_in, .miso_out, .miso_oe);
	spi_peer_model peer (.sck(sck_out), .cs_n(cs_n_out), .mosi(mosi_out), .miso(peer_miso), .reply, .heard);
	always @(posedge pclk) if (cs_n_out === 1'b1) gap <= gap + 1;
	else begin
		if (gap != 0) last_gap <= gap;
		gap <= 0;
	end
	task automatic final_report;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		if (pready !== 1'b1) begin
			errors++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_STAT, 32'h0);
			n++;
		end while (rd[ST_BSY] !== 1'b0 && n < 400);
		if (rd[ST_BSY] !== 1'b0) begin
			errors++;
			final_report();
		end
		repeat (8) @(posedge pclk);
	endtask
	task automatic sframe(input logic [15:0] w);
		cs_n_in <= 1'b0;
		oe_seen = 1'b0;
		repeat (8) @(posedge pclk);
		for (int b = 15; b >= 0; b--) begin
			mosi_in <= w[b];
			repeat (4) @(posedge pclk);
			sck_in <= 1'b1;
			got = {got[14:0], miso_out};
			oe_seen = oe_seen | miso_oe;
			repeat (4) @(posedge pclk);
			sck_in <= 1'b0;
		end
		repeat (8) @(posedge pclk);
		cs_n_in <= 1'b1;
		mosi_in <= ~w[0];
		@(posedge pclk);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_CTRL1, 32'h0);
		check(rd, CTRL1_RST);
		apb(1'b0, OFS_STAT, 32'h0);
		check(rd, 32'h3);
		apb(1'b1, OFS_CTRL1, 32'hffff_ffff);
		apb(1'b0, OFS_CTRL1, 32'h0);
		check(rd, 32'h002f_dfbe);
		apb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, OFS_CTRL0, 32'hf);
		foreach (rows[i]) begin
			apb(1'b1, OFS_CTRL1, 32'(rows[i].code) << TXO_LSB | 32'(rows[i].code) << RXO_LSB
				| 32'(i) << WAIT_LSB | 32'(i % 2) << DLY_BIT | 32'h2);
			apb(1'b1, OFS_DATA, 32'hdead_12c5);
			apb(1'b1, OFS_DATA, 32'hbeef_12c5);
			wait_idle();
			check({29'h0, sck_oe, mosi_oe, cs_n_oe}, 32'h7);
			check({16'h0, heard}, {16'h0, rows[i].line_v});
			check(32'(last_gap >= 8 * i && last_gap <= 8 * i + 6), 32'h1);
			for (int k = 0; k < 3; k++) begin
				apb(1'b0, OFS_DATA, 32'h0);
				check(rd, k < 2 ? {16'h0, rows[i].rx_v} : 32'h0);
			end
		end
		apb(1'b1, OFS_CTRL1, 32'h0);
		apb(1'b1, OFS_DATA, 32'h5);
		repeat (200) @(posedge pclk);
		apb(1'b0, OFS_STAT, 32'h0);
		check(32'(rd[ST_TFE]), 32'h0);
		apb(1'b0, OFS_ISTAT, 32'h0);
		apb(1'b1, OFS_IMASK, 32'h1);
		apb(1'b1, OFS_CTRL1, 32'h2 | 32'(THR_FOUR) << RXT_LSB);
		apb(1'b1, OFS_DATA, 32'h1);
		apb(1'b1, OFS_DATA, 32'h2);
		wait_idle();
		check(32'(irq), 32'h0);
		apb(1'b1, OFS_DATA, 32'h3);
		wait_idle();
		check(32'(irq), 32'h1);
		apb(1'b1, OFS_IMASK, 32'h0);
		repeat (2) @(posedge pclk);
		check(32'(irq), 32'h0);
		apb(1'b0, OFS_ISTAT, 32'h0);
		check(rd, 32'h3);
		apb(1'b0, OFS_DATA, 32'h0);
		apb(1'b0, OFS_ISTAT, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFS_ISTAT, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, OFS_CTRL1, 32'(THR_FOUR) << TXT_LSB);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, OFS_DATA, 32'(k));
			apb(1'b0, OFS_ISTAT, 32'h0);
			check(rd, k < 3 ? 32'h1 : 32'h3);
		end
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_STAT, 32'h0);
		check(rd, 32'h3);
		apb(1'b1, OFS_CTRL0, 32'hf);
		apb(1'b1, OFS_CTRL1, 32'he);
		sframe(16'ha5c3);
		check(32'(oe_seen), 32'h0);
		check({29'h0, sck_oe, mosi_oe, cs_n_oe}, 32'h0);
		apb(1'b0, OFS_DATA, 32'h0);
		check(rd, 32'h0000_a5c3);
		apb(1'b1, OFS_CTRL1, 32'h6);
		apb(1'b1, OFS_DATA, 32'hffff_7e81);
		sframe(16'h0f0f);
		check(32'(oe_seen), 32'h1);
		check({16'h0, got}, 32'h0000_7e81);
		apb(1'b0, OFS_DATA, 32'h0);
		check(rd, 32'h0000_0f0f);
		final_report();
	end
endmodule
